/* logic/psbwl_regs.svh */
// Constants of the burst, WAIT and latency block of the multiplexed-bus memory
// What this block does
// - Wrap bit 0 steps addresses modulo the burst length inside the aligned block, 1 steps linearly.
// - Drive code 00 gives full, 01 half (reset) and 10 quarter strength; 11 is reserved.
// - With WAIT timing 0, data turns valid or invalid in step with WAIT changing.
// - With WAIT timing 1 (reset), WAIT changes one clock before data turns valid or invalid.
// - WAIT polarity 1 (reset) makes asserted WAIT high, 0 makes it low.
// - The three-bit latency code sets the clocks from burst start until data appears on the bus.
// - Latency counts clocks from burst start until data appears; the transfer is on the next clock.
// - Variable latency codes 010, 011 (reset) and 100 give 2, 3, 4 clocks, doubled on refresh collision.
// - Variable latency mode (reset) holds WAIT asserted through the extra cycles of a collision.
// - Fixed latency mode starts data after exactly the programmed count, whatever refresh does.
// - Burst length is 4, 8, 16, 32 or continuous (reset), and linear addresses roll over to zero.
// - The operating-mode bit selects synchronous bursts at 0 or asynchronous operation at 1 (reset).
// - The host writes reserved bits as zero and all sixteen bits read back exactly as written.
`ifndef PSBWL_REGS_SVH
`define PSBWL_REGS_SVH
`define PSBWL_SEL_BCR 2'h2
`define PSBWL_BCR_RST 16'h9D1F
`define PSBWL_BL4 3'h1
`define PSBWL_BL8 3'h2
`define PSBWL_BL16 3'h3
`define PSBWL_BL32 3'h4
`define PSBWL_BLCONT 3'h7
`define PSBWL_DRV_HALF 2'h1
`define PSBWL_DRV_RSV 2'h3
`define PSBWL_LAT_DEF 4'h3
`define PSBWL_LAT_C0 4'h8
`define PSBWL_CLK_NS 10
`define PSBWL_REF_NS 3900
`define PSBWL_REF_CYC (`PSBWL_REF_NS / `PSBWL_CLK_NS)
`define PSBWL_REF_BUSY_NS 60
`define PSBWL_REF_BUSY_CYC ((`PSBWL_REF_BUSY_NS + `PSBWL_CLK_NS - 1) / `PSBWL_CLK_NS)
`define PSBWL_REF_GUARD 16
`define PSBWL_FIFO_DEPTH 16
`endif

/* logic/psbwl_pkg.sv */
// Types shared by the burst, WAIT and latency block
package psbwl_pkg;
    typedef struct packed {
        logic       async_mode;
        logic       lat_fixed;
        logic [2:0] lat_code;
        logic       wait_pol;
        logic       rsv9;
        logic       wait_cfg;
        logic [1:0] rsv7_6;
        logic [1:0] drive;
        logic       no_wrap;
        logic [2:0] blen;
    } psbwl_bcr_t;
    typedef enum logic [1:0] {
        PSBWL_DRV_FULL = 2'h0,
        PSBWL_DRV_HALF = 2'h1,
        PSBWL_DRV_QUARTER = 2'h2
    } psbwl_drive_t;
    typedef enum {PS_IDLE, PS_LAT, PS_DATA} psbwl_state_t;
endpackage

/* logic/psbwl_core.sv */
// Write FIFO and the burst, WAIT and latency engine of the memory
`include "psbwl_regs.svh"

module psbwl_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AB = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AB) != DEPTH) begin
            $error("psbwl_fifo: DEPTH must be a power of two");
        end
    end
    logic [W-1:0] buf_q [DEPTH];
    logic [AB:0] wp, rp, next_wp, next_rp;
    logic push, pop;

    always_comb begin
        // Full needs the extra pointer bit; a plain AB-bit depth would read as zero
        in_ready_o = (wp - rp) != (AB+1)'(DEPTH);
        out_valid_o = wp != rp;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wp = wp + (AB+1)'(push);
        next_rp = rp + (AB+1)'(pop);
        out_data_o = buf_q[rp[AB-1:0]];
        level_o = wp - rp;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // Storage needs no reset; only the pointers say what is valid
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            buf_q[wp[AB-1:0]] <= in_data_i;
        end
    end
endmodule

module psbwl_core
    import psbwl_pkg::*;
#(
    parameter int AW = 8,
    parameter int DEPTH = `PSBWL_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Bus control
    input wire logic ce_b_i,
    input wire logic adv_b_i,
    input wire logic we_b_i,
    input wire logic cre_i,
    input wire logic [3:0] addr_hi_i,
    // Multiplexed address and data, and WAIT
    input wire logic [15:0] adq_i,
    output logic [15:0] adq_o,
    output logic adq_oe_b_o,
    output logic wait_o,
    // Configuration seen by the pads
    output logic [1:0] drive_o,
    output logic async_mode_o
);
    localparam int REF_CYC = `PSBWL_REF_CYC;
    localparam int RB = $clog2(REF_CYC);
    localparam int W = AW + 16;
    initial begin
        if (AW < 5 || AW > 16 || DEPTH < 4) begin
            $error("psbwl_core: AW must be 5..16 and DEPTH at least 4");
        end
    end

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [15:0] data;
    } psbwl_wr_t;

    psbwl_bcr_t bus_configuration, next_bcr;
    psbwl_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [AW-1:0] addr, next_addr, addr_d, next_addr_d;
    logic is_wr, next_is_wr, is_cfg, next_is_cfg;
    logic a_q, next_a, dv, next_dv;
    logic [15:0] next_adq;
    logic next_oe_b, next_wait;
    logic [1:0] next_drive;
    logic [RB-1:0] ref_cnt, next_ref_cnt;
    logic [3:0] ref_busy, next_ref_busy;
    logic [15:0] mem [2**AW];
    logic start, cfg_hit, arr_start, collide, room, wait_act;
    logic fifo_in_ready, fifo_out_valid, drain;
    psbwl_wr_t fifo_in, fifo_out;
    logic [$clog2(DEPTH):0] level;

    function automatic logic [3:0] lat_f(input psbwl_bcr_t b);
        logic [3:0] n;
        n = {1'b0, b.lat_code};
        if (b.lat_fixed && b.lat_code == 3'h0) begin
            n = `PSBWL_LAT_C0;
        end else if (b.lat_code < 3'h2 || b.lat_code > (b.lat_fixed ? 3'h6 : 3'h4)) begin
            n = `PSBWL_LAT_DEF;
        end
        return n;
    endfunction

    function automatic logic [AW-1:0] step_f(input logic [AW-1:0] a, input psbwl_bcr_t b);
        logic [AW-1:0] m;
        unique case (b.blen)
            `PSBWL_BL4: m = AW'(3);
            `PSBWL_BL8: m = AW'(7);
            `PSBWL_BL16: m = AW'(15);
            `PSBWL_BL32: m = AW'(31);
            default: m = '0;
        endcase
        if (!b.no_wrap && m != '0) begin
            return (a & ~m) | ((a + AW'(1)) & m);
        end
        return a + AW'(1);
    endfunction

    psbwl_fifo #(.W(W), .DEPTH(DEPTH)) u_wr_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(dv && is_wr && !is_cfg),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(ref_busy == 4'h0),
        .out_data_o(fifo_out),
        .level_o(level)
    );

    always_comb begin
        start = !ce_b_i && !adv_b_i;
        cfg_hit = start && cre_i && addr_hi_i[3:2] == `PSBWL_SEL_BCR;
        arr_start = start && !cre_i && !bus_configuration.async_mode;
        // A refresh running or about to start collides with the access
        collide = ref_busy != 4'h0 || ref_cnt < RB'(`PSBWL_REF_GUARD);
        // Two words may already be on their way into the FIFO
        room = level <= ($clog2(DEPTH)+1)'(DEPTH - 3);
        fifo_in = '{addr: addr_d, data: adq_i};
        drain = fifo_out_valid && ref_busy == 4'h0;
        next_bcr = bus_configuration;
        next_state = state;
        next_cnt = cnt;
        next_addr = addr;
        next_is_wr = is_wr;
        next_is_cfg = is_cfg;
        if (cfg_hit && !we_b_i) begin
            next_bcr = adq_i;
        end
        if (ce_b_i) begin
            next_state = PS_IDLE;
        end else if (cfg_hit || arr_start) begin
            next_state = PS_LAT;
            next_is_wr = !we_b_i;
            next_is_cfg = cfg_hit;
            next_addr = adq_i[AW-1:0];
            next_cnt = lat_f(bus_configuration);
            if (arr_start && !bus_configuration.lat_fixed && collide) begin
                next_cnt = next_cnt << 1;
            end
        end else if (state == PS_LAT) begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
                next_state = PS_DATA;
            end
        end
        next_a = next_state == PS_DATA && (!next_is_wr || room);
        if (a_q && state == PS_DATA && !start) begin
            next_addr = step_f(addr, bus_configuration);
        end
        next_dv = a_q && !ce_b_i && !start;
        next_addr_d = addr;
        next_adq = is_cfg ? 16'(bus_configuration) : mem[addr];
        next_oe_b = !(next_dv && !is_wr);
        // Early timing tracks the stage ahead, late timing tracks the bus itself
        if (bus_configuration.wait_cfg) begin
            wait_act = next_state != PS_IDLE && !next_a;
        end else begin
            wait_act = next_state != PS_IDLE && !next_dv;
        end
        next_wait = bus_configuration.wait_pol ? wait_act : !wait_act;
        next_drive = bus_configuration.drive == `PSBWL_DRV_RSV ? `PSBWL_DRV_HALF : bus_configuration.drive;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_configuration <= `PSBWL_BCR_RST;
            state <= PS_IDLE;
            cnt <= 4'h0;
            addr <= '0;
            addr_d <= '0;
            is_wr <= 1'b0;
            is_cfg <= 1'b0;
            a_q <= 1'b0;
            dv <= 1'b0;
            adq_o <= 16'h0000;
            adq_oe_b_o <= 1'b1;
            wait_o <= 1'b0;
            drive_o <= `PSBWL_DRV_HALF;
            async_mode_o <= 1'b1;
        end else begin
            bus_configuration <= next_bcr;
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            addr_d <= next_addr_d;
            is_wr <= next_is_wr;
            is_cfg <= next_is_cfg;
            a_q <= next_a;
            dv <= next_dv;
            adq_o <= next_adq;
            adq_oe_b_o <= next_oe_b;
            wait_o <= next_wait;
            drive_o <= next_drive;
            async_mode_o <= next_bcr.async_mode;
        end
    end

    // Hidden refresh: the array port is taken, so writes queue in the FIFO
    always_comb begin
        next_ref_cnt = ref_cnt - RB'(1);
        next_ref_busy = ref_busy == 4'h0 ? 4'h0 : ref_busy - 4'h1;
        if (ref_cnt == '0) begin
            next_ref_cnt = RB'(REF_CYC - 1);
            next_ref_busy = 4'(`PSBWL_REF_BUSY_CYC);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_cnt <= RB'(REF_CYC - 1);
            ref_busy <= 4'h0;
        end else begin
            ref_cnt <= next_ref_cnt;
            ref_busy <= next_ref_busy;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (drain) begin
            mem[fifo_out.addr] <= fifo_out.data;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    logic hold, rd3;
    assign hold = !ce_b_i && adv_b_i;
    assign rd3 = arr_start && we_b_i && bus_configuration.lat_code == 3'h3;

    sequence s_var_clean;
        rd3 && !bus_configuration.lat_fixed && !collide ##1 hold [*4];
    endsequence
    sequence s_var_coll;
        rd3 && !bus_configuration.lat_fixed && collide ##1 hold [*7];
    endsequence
    sequence s_fixed;
        rd3 && bus_configuration.lat_fixed ##1 hold [*4];
    endsequence

    wrap_block_a: assert property (
        a_q && state == PS_DATA && hold && !bus_configuration.no_wrap && bus_configuration.blen == `PSBWL_BL4
        |=> addr[AW-1:2] == $past(addr[AW-1:2]))
        else $error("wrapped burst left its block");
    roll_over_a: assert property (
        a_q && state == PS_DATA && hold && bus_configuration.blen == `PSBWL_BLCONT && addr == '1
        |=> addr == '0)
        else $error("linear burst did not roll over");
    drive_rsv_a: assert property (
        bus_configuration.drive == `PSBWL_DRV_RSV |=> drive_o == `PSBWL_DRV_HALF)
        else $error("reserved drive code not mapped");
    wait_early_a: assert property (
        bus_configuration.wait_cfg && $changed(wait_o) && wait_o != bus_configuration.wait_pol && hold && state == PS_DATA
        |=> dv)
        else $error("early WAIT not one clock ahead");
    wait_late_a: assert property (
        !bus_configuration.wait_cfg && $changed(wait_o) && wait_o != bus_configuration.wait_pol && state == PS_DATA |-> dv)
        else $error("late WAIT not in step with data");
    wait_idle_a: assert property (
        ce_b_i |=> wait_o == !$past(bus_configuration.wait_pol))
        else $error("idle WAIT level wrong");
    var_lat_a: assert property (
        s_var_clean |-> !dv ##1 dv)
        else $error("variable latency count wrong");
    coll_lat_a: assert property (
        s_var_coll |-> !dv && $past(wait_o) == bus_configuration.wait_pol ##1 dv)
        else $error("collision latency wrong");
    fixed_lat_a: assert property (
        s_fixed |-> !dv ##1 dv)
        else $error("fixed latency count wrong");
    async_gate_a: assert property (
        start && !cre_i && bus_configuration.async_mode |=> state == PS_IDLE)
        else $error("burst started in asynchronous mode");
    read_back_a: assert property (
        cfg_hit && !we_b_i |=> 16'(bus_configuration) == $past(adq_i))
        else $error("configuration not stored as written");
endmodule

/* verif/psbwl_ctl_model.sv */
// Controller model: drives the multiplexed bus and paces transfers by WAIT
module psbwl_ctl_model (
    // Clock
    input wire logic ref_clk_i,
    // Requests to the memory
    output logic ce_b_o,
    output logic adv_b_o,
    output logic we_b_o,
    output logic cre_o,
    output logic [3:0] addr_hi_o,
    output logic [15:0] adq_o,
    // Answers from the memory
    input wire logic [15:0] adq_i,
    input wire logic adq_oe_b_i,
    input wire logic wait_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pol = 1'b1;
    logic early = 1'b1;
    logic [15:0] rbuf [128];
    int oe_bad = 0;
    initial begin
        ce_b_o = 1'b1;
        adv_b_o = 1'b1;
        we_b_o = 1'b1;
        cre_o = 1'b0;
        addr_hi_o = 4'h0;
        adq_o = 16'h0000;
    end
    function automatic logic [15:0] word(input logic [7:0] x);
        return {8'hC3, x ^ 8'h5A};
    endfunction
    task automatic burst(input logic reg_sel, input logic wr, input logic [15:0] a, input int n, output int lat);
        int e;
        int got;
        logic prev;
        logic now;
        logic rdy;
        e = 0;
        got = 0;
        prev = 1'b1;
        lat = 0;
        @(posedge ref_clk_i);
        #1;
        ce_b_o = 1'b0;
        adv_b_o = 1'b0;
        we_b_o = ~wr;
        cre_o = reg_sel;
        addr_hi_o = reg_sel ? 4'h8 : 4'h0;
        adq_o = a;
        @(posedge ref_clk_i);
        #1;
        adv_b_o = 1'b1;
        cre_o = 1'b0;
        adq_o = wr ? word(a[7:0]) : ~adq_o;
        while (got < n && e < 400) begin
            @(posedge ref_clk_i);
            e++;
            now = (wait_i === pol);
            // Register reads are taken on the driven bus; array words wait for WAIT to clear
            rdy = reg_sel ? (adq_oe_b_i === 1'b0) : (e >= 2 && !(early ? prev : now));
            if (rdy && !wr) begin
                rbuf[got] = adq_i;
                oe_bad += (adq_oe_b_i !== 1'b0);
            end
            if (rdy && got == 0) begin
                lat = e;
            end
            got += rdy;
            prev = now;
            #1;
            adq_o = wr ? word(8'(a[7:0] + got)) : ~adq_o;
        end
        ce_b_o = 1'b1;
        adq_o = ~adq_o;
    endtask
endmodule

/* verif/test_psram_burst_wait_latency_cfg.sv */
// Self-checking bench for the burst, WAIT and latency engine
module test_psram_burst_wait_latency_cfg
    import psbwl_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce_b, adv_b, we_b, cre, adq_oe_b, wait_s, async_mode;
    logic [3:0] addr_hi;
    logic [15:0] adq_in, adq_out;
    logic [1:0] drive;
    int num_errors = 0;
    int check_count = 0;
    always #5 ref_clk = ~ref_clk;
    psbwl_core #(.AW(8), .DEPTH(16)) i_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_b_i(ce_b),
        .adv_b_i(adv_b), .we_b_i(we_b), .cre_i(cre), .addr_hi_i(addr_hi), .adq_i(adq_in), .adq_o(adq_out),
        .adq_oe_b_o(adq_oe_b), .wait_o(wait_s), .drive_o(drive), .async_mode_o(async_mode));
    psbwl_ctl_model i_ctl (.ref_clk_i(ref_clk), .ce_b_o(ce_b), .adv_b_o(adv_b), .we_b_o(we_b), .cre_o(cre),
        .addr_hi_o(addr_hi), .adq_o(adq_in), .adq_i(adq_out), .adq_oe_b_i(adq_oe_b), .wait_i(wait_s));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Reserved bits always go out as zero
    function automatic psbwl_bcr_t mk(input logic fx, input logic [2:0] code, input logic pol, input logic wc,
                                      input logic [1:0] drv, input logic nw, input logic [2:0] bl);
        return '{1'b0, fx, code, pol, 1'b0, wc, 2'b00, drv, nw, bl};
    endfunction
    task automatic cfg(input psbwl_bcr_t b);
        int lat;
        i_ctl.burst(1'b1, 1'b1, b, 0, lat);
        i_ctl.pol = b.wait_pol;
        i_ctl.early = b.wait_cfg;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rd_cmp(input logic [7:0] a, input int n, input int len, output int lat);
        logic [7:0] x;
        i_ctl.burst(1'b0, 1'b0, {8'h00, a}, n, lat);
        for (int i = 0; i < n; i++) begin
            x = (len == 0) ? 8'(a + i) : 8'((a & ~(len - 1)) | ((a + i) & (len - 1)));
            chk("burst word", i_ctl.word(x), i_ctl.rbuf[i]);
        end
        chk("bus driven with data", 16'h0000, 16'(i_ctl.oe_bad));
    endtask
    task automatic test_reset();
        int lat;
        chk("drive", 16'h0001, {14'h0, drive});
        chk("async mode", 16'h0001, {15'h0, async_mode});
        chk("idle wait", 16'h0000, {15'h0, wait_s});
        i_ctl.burst(1'b1, 1'b0, 16'h0000, 1, lat);
        chk("reset config", 16'h9D1F, i_ctl.rbuf[0]);
        $display("reset test done");
    endtask
    task automatic test_regs();
        int lat;
        psbwl_bcr_t b;
        for (int i = 0; i < 4; i++) begin
            b = mk(1'b0, 3'h3, i[0], i[1], i[1:0], 1'b0, 3'h7);
            b.async_mode = i[1];
            cfg(b);
            i_ctl.burst(1'b1, 1'b0, 16'h0000, 1, lat);
            chk("config readback", b, i_ctl.rbuf[0]);
            chk("drive", (i == 3) ? 16'h0001 : 16'(i), {14'h0, drive});
            chk("async mode", {15'h0, i[1]}, {15'h0, async_mode});
            chk("idle wait", {15'h0, ~i[0]}, {15'h0, wait_s});
        end
        $display("register test done");
    endtask
    task automatic test_fill();
        int lat;
        cfg(mk(1'b0, 3'h3, 1'b1, 1'b1, 2'h1, 1'b1, 3'h7));
        // A write longer than the FIFO streams through it, since the FIFO drains a word each clock outside refresh
        i_ctl.burst(1'b0, 1'b1, 16'h0000, 128, lat);
        repeat (60) @(posedge ref_clk);
        rd_cmp(8'h00, 128, 0, lat);
        i_ctl.burst(1'b0, 1'b1, 16'h00FC, 8, lat);
        repeat (40) @(posedge ref_clk);
        rd_cmp(8'hFC, 8, 0, lat);
        $display("fill and rollover test done");
    endtask
    task automatic test_wrap();
        int lat;
        int len;
        for (int i = 0; i < 8; i++) begin
            len = 4 << (i % 4);
            cfg(mk(1'b0, 3'h3, 1'b1, 1'b1, 2'h1, i[2], 3'(1 + i % 4)));
            rd_cmp(8'(32 + len - 2), len + 2, i[2] ? 0 : len, lat);
        end
        $display("wrap test done");
    endtask
    task automatic test_latency();
        int lat;
        int n;
        logic [2:0] code;
        // At 100 MHz only these codes stay inside the clock limit of their mode
        for (int i = 0; i < 8; i++) begin
            code = i[2] ? (i[0] ? 3'h0 : 3'h6) : (i[0] ? 3'h4 : 3'h3);
            n = (code == 3'h0) ? 8 : int'(code);
            cfg(mk(i[2], code, i[1], i[0] ^ i[1], 2'h0, 1'b1, 3'h7));
            rd_cmp(8'h10, 4, 0, lat);
            chk("first data edge", (!i[2] && lat == 2 * n + 2) ? 16'(2 * n + 2) : 16'(n + 2), 16'(lat));
        end
        $display("latency test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        test_reset();
        test_regs();
        test_fill();
        test_wrap();
        test_latency();
        wrap_up();
    end
endmodule
